// ==== design/fgr_pkg.sv ====
//
// Contract
// - Time-to-empty is available capacity over averaged current, packed as hours 15:10, 1.5 min steps 9:4 and 5.625 s steps 3:0.
// - With the rate option on, the hypothetical load rate replaces averaged current as the divisor.
// - Slow internal resistance is a 16-bit value of 2^-12 ohm per count with a 10 milliohm sense resistor.
// - The cycle odometer counts one per 1% charge plus 1% discharge, 100 counts being one full cycle.
// - Available capacity is the mixed result less rate-lost capacity, 16 bits at 0.5 mAh per count.
// - Termination full capacity is the reported remaining capacity caught at charge termination and held until the next one.
// - A 16-bit correction factor in units of 2^-21 derives compensated full capacity from nominal capacity and temperature.
// - The charge learning accumulator only rises, on charge and discharge alike, 16 mAh per count, capped at eight times remaining capacity (code: a quarter).
// - The percent learning accumulator does the same from voltage-gauge state of charge at 1/64 % per count.
// - Voltage-gauge remaining capacity is reported in its own 16-bit register, free of coulomb counting.
package fgr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FGR_OFS_EMPTY_TIME = 8'h11;
    localparam logic [7:0] FGR_OFS_SLOW_RES = 8'h14;
    localparam logic [7:0] FGR_OFS_CYC = 8'h17;
    localparam logic [7:0] FGR_OFS_AVAIL = 8'h1f;
    localparam logic [7:0] FGR_OFS_FULL_TIME = 8'h20;
    localparam logic [7:0] FGR_OFS_FCREP = 8'h35;
    localparam logic [7:0] FGR_OFS_CORR = 8'h37;
    localparam logic [7:0] FGR_OFS_DQ = 8'h45;
    localparam logic [7:0] FGR_OFS_DP = 8'h46;
    localparam logic [7:0] FGR_OFS_VFREM = 8'h4a;

    // ------------------------------------------------------------
    // Reset values and arithmetic constants
    // ------------------------------------------------------------
    localparam logic [15:0] FGR_RST_WORD = 16'h0000;
    localparam logic [15:0] FGR_RST_CORR = 16'h0000;
    localparam logic [15:0] FGR_SAT = 16'hffff;
    localparam int FGR_EMPTY_SHIFT = 5;
    localparam int FGR_CORR_SHIFT = 21;
    localparam int FGR_DQ_LIM_SHIFT = 2;
    localparam int FGR_DP_SHIFT = 2;
    localparam logic signed [7:0] FGR_TEMP_REF = 8'sh19;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] hr;
        logic [5:0] mn;
        logic [3:0] sec;
    } fgr_time_t;

    typedef struct packed {
        logic signed [15:0] averaged_current;
        logic signed [15:0] hypothetical_load_rate;
        logic [15:0] available_capacity;
        logic [15:0] slow_resistance;
        fgr_time_t time_to_full;
        logic [15:0] reported_remaining_capacity;
        logic [15:0] remaining_capacity;
        logic [15:0] nominal_full_capacity;
        logic [15:0] voltage_gauge_capacity;
        logic [15:0] voltage_gauge_soc;
        logic signed [7:0] temperature;
    } fgr_gauge_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [15:0] wdata;
    } fgr_req_t;

    typedef enum logic [1:0] {
        FGR_DIV_IDLE = 2'b00,
        FGR_DIV_RUN = 2'b01,
        FGR_DIV_DONE = 2'b11
    } fgr_div_state_t;

endpackage

// ==== design/fgr_divider.sv ====
`timescale 1ns/10ps
`default_nettype none
module fgr_divider
    import fgr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Operation
    input wire logic start_i,
    input wire logic [31:0] dividend_i,
    input wire logic [15:0] divisor_i,
    output logic busy_o,
    output logic done_o,
    output logic [31:0] quotient_o
);

    fgr_div_state_t state_q;
    logic [31:0] quo_q;
    logic [16:0] rem_q;
    logic [15:0] dsr_q;
    logic [4:0] cnt_q;
    logic [16:0] trial;

    // One restoring step per cycle, 32 cycles a division
    assign trial = {rem_q[15:0], quo_q[31]} - {1'b0, dsr_q};

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            state_q <= FGR_DIV_IDLE;
            cnt_q <= 5'h00;
        end
        else
        begin
            unique case (state_q)
                FGR_DIV_IDLE:
                begin
                    if (start_i)
                    begin
                        state_q <= FGR_DIV_RUN;
                        cnt_q <= 5'h00;
                    end
                end
                FGR_DIV_RUN:
                begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h1f)
                    begin
                        state_q <= FGR_DIV_DONE;
                    end
                end
                FGR_DIV_DONE:
                begin
                    state_q <= FGR_DIV_IDLE;
                end
                default:
                begin
                    state_q <= FGR_DIV_IDLE;
                end
            endcase
        end
    end

    // Datapath; quotient holds after done until the next start
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            quo_q <= 32'h0000_0000;
            rem_q <= 17'h0_0000;
            dsr_q <= 16'h0000;
        end
        else if (state_q == FGR_DIV_IDLE && start_i)
        begin
            quo_q <= dividend_i;
            rem_q <= 17'h0_0000;
            dsr_q <= divisor_i;
        end
        else if (state_q == FGR_DIV_RUN)
        begin
            if (!trial[16])
            begin
                rem_q <= trial;
                quo_q <= {quo_q[30:0], 1'b1};
            end
            else
            begin
                rem_q <= {rem_q[15:0], quo_q[31]};
                quo_q <= {quo_q[30:0], 1'b0};
            end
        end
    end

    assign busy_o = (state_q != FGR_DIV_IDLE);
    assign done_o = (state_q == FGR_DIV_DONE);
    assign quotient_o = quo_q;

endmodule
`default_nettype wire

// ==== design/fgr_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module fgr_regs
    import fgr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register access port
    input wire fgr_req_t req_i,
    output logic [15:0] rdata_o,
    output logic ack_o,
    output logic err_o,
    // Gauge engine results and events
    input wire fgr_gauge_t gauge_i,
    input wire logic sample_i,
    input wire logic rate_sub_en_i,
    input wire logic charge_term_i,
    input wire logic soc_step_i,
    input wire logic charge_quantum_i,
    // Derived result
    output logic [15:0] compensated_full_capacity_o
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic fgr_mapped(input logic [7:0] a);
        fgr_mapped = (a == FGR_OFS_EMPTY_TIME) || (a == FGR_OFS_SLOW_RES) ||
            (a == FGR_OFS_CYC) || (a == FGR_OFS_AVAIL) ||
            (a == FGR_OFS_FULL_TIME) || (a == FGR_OFS_FCREP) ||
            (a == FGR_OFS_CORR) || (a == FGR_OFS_DQ) ||
            (a == FGR_OFS_DP) || (a == FGR_OFS_VFREM);
    endfunction

    function automatic logic [15:0] fgr_sat_add(input logic [15:0] a,
        input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        fgr_sat_add = s[16] ? FGR_SAT : s[15:0];
    endfunction

    logic [15:0] empty_q, slow_q, cyc_q, avail_q, full_q, fcrep_q;
    logic [15:0] factor_q, dq_q, dp_q, vfrem_q, comp_q;
    logic upd_pend_q, term_pend_q, empty_pend_q, half_cyc_q;
    logic [15:0] soc_prev_q;
    logic [1:0] dp_res_q;
    logic rd, upd, term;
    logic wr_cyc, wr_factor, wr_dq, wr_dp;
    logic signed [15:0] divisor_s;
    logic [15:0] divisor;
    logic div_busy, div_done, div_start, empty_load;
    logic [31:0] quotient;
    logic [26:0] empty_full;
    logic [15:0] empty_word;

    assign rd = req_i.rd;
    assign wr_cyc = req_i.wr && (req_i.addr == FGR_OFS_CYC);
    assign wr_factor = req_i.wr && (req_i.addr == FGR_OFS_CORR);
    assign wr_dq = req_i.wr && (req_i.addr == FGR_OFS_DQ);
    assign wr_dp = req_i.wr && (req_i.addr == FGR_OFS_DP);

    // ------------------------------------------------------------
    // Snapshot deferral around reads
    // ------------------------------------------------------------
    // A fresh snapshot waits while a read is sampled, so the host never
    // sees a word that changes under it.
    assign upd = (sample_i || upd_pend_q) && !rd;
    assign term = (charge_term_i || term_pend_q) && !rd;

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            upd_pend_q <= 1'b0;
            term_pend_q <= 1'b0;
        end
        else
        begin
            upd_pend_q <= (sample_i || upd_pend_q) && rd;
            term_pend_q <= (charge_term_i || term_pend_q) && rd;
        end
    end

    // Plain results copied from the engine at a snapshot
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            slow_q <= FGR_RST_WORD;
            avail_q <= FGR_RST_WORD;
            full_q <= FGR_RST_WORD;
            vfrem_q <= FGR_RST_WORD;
        end
        else if (upd)
        begin
            slow_q <= gauge_i.slow_resistance;
            avail_q <= gauge_i.available_capacity;
            full_q <= gauge_i.time_to_full;
            vfrem_q <= gauge_i.voltage_gauge_capacity;
        end
    end

    // Full capacity caught only at charge termination, immune to temperature
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            fcrep_q <= FGR_RST_WORD;
        end
        else if (term)
        begin
            fcrep_q <= gauge_i.reported_remaining_capacity;
        end
    end

    // ------------------------------------------------------------
    // Time to empty
    // ------------------------------------------------------------
    // Discharge current is negative; charging or idle gives no divide
    // and the result saturates.
    assign divisor_s = rate_sub_en_i ? gauge_i.hypothetical_load_rate :
        gauge_i.averaged_current;
    assign divisor = 16'h0000 - divisor_s;
    assign div_start = upd && !div_busy && divisor_s[15] && 1'b1;

    fgr_divider u_div (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .start_i(div_start),
        .dividend_i({gauge_i.available_capacity, 16'h0000}),
        .divisor_i(divisor),
        .busy_o(div_busy),
        .done_o(div_done),
        .quotient_o(quotient)
    );

    // Shift leaves a word of 5.625 s steps, which is exactly hr:mn:sec
    assign empty_full = quotient[31:FGR_EMPTY_SHIFT];
    assign empty_word = (|empty_full[26:16]) ? FGR_SAT : empty_full[15:0];
    assign empty_load = (div_done || empty_pend_q) && !rd;

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            empty_q <= FGR_RST_WORD;
            empty_pend_q <= 1'b0;
        end
        else
        begin
            empty_pend_q <= (div_done || empty_pend_q) && rd;
            if (upd && !divisor_s[15])
            begin
                empty_q <= FGR_SAT;
            end
            else if (empty_load)
            begin
                empty_q <= empty_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Learning accumulators and odometer
    // ------------------------------------------------------------
    // Two one-percent steps (charge plus discharge) make one count;
    // a host write keeps any step that lands in the same cycle.
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            cyc_q <= FGR_RST_WORD;
            half_cyc_q <= 1'b0;
        end
        else
        begin
            if (soc_step_i)
            begin
                half_cyc_q <= !half_cyc_q;
            end
            cyc_q <= fgr_sat_add(wr_cyc ? req_i.wdata : cyc_q,
                {15'h0000, soc_step_i && half_cyc_q});
        end
    end

    // Charge accumulator only rises; capped at a quarter of remaining capacity
    always_ff @(posedge clk_i)
    begin
        logic [15:0] base, lim, nxt;
        base = wr_dq ? req_i.wdata : dq_q;
        lim = gauge_i.remaining_capacity >> FGR_DQ_LIM_SHIFT;
        nxt = fgr_sat_add(base, {15'h0000, charge_quantum_i});
        if (!nrst_i)
        begin
            dq_q <= FGR_RST_WORD;
        end
        else
        begin
            dq_q <= (charge_quantum_i && nxt > lim && !wr_dq) ? base : nxt;
        end
    end

    // Percent accumulator from absolute voltage-gauge SOC movement
    always_ff @(posedge clk_i)
    begin
        logic [15:0] dlt;
        logic [16:0] sum;
        dlt = (gauge_i.voltage_gauge_soc >= soc_prev_q) ?
            gauge_i.voltage_gauge_soc - soc_prev_q :
            soc_prev_q - gauge_i.voltage_gauge_soc;
        sum = {1'b0, dlt} + {15'h0000, dp_res_q};
        if (!nrst_i)
        begin
            dp_q <= FGR_RST_WORD;
            dp_res_q <= 2'h0;
            soc_prev_q <= FGR_RST_WORD;
        end
        else if (upd)
        begin
            soc_prev_q <= gauge_i.voltage_gauge_soc;
            dp_res_q <= sum[1:0];
            dp_q <= fgr_sat_add(wr_dp ? req_i.wdata : dp_q,
                {1'b0, sum[16:FGR_DP_SHIFT]});
        end
        else if (wr_dp)
        begin
            dp_q <= req_i.wdata;
        end
    end

    // ------------------------------------------------------------
    // Temperature compensation
    // ------------------------------------------------------------
    // Colder than reference lowers full capacity at once, no charge needed
    always_ff @(posedge clk_i)
    begin
        logic [7:0] cold;
        logic [39:0] prod;
        logic [18:0] corr;
        cold = (gauge_i.temperature < FGR_TEMP_REF) ?
            8'(FGR_TEMP_REF - gauge_i.temperature) : 8'h00;
        prod = 40'(gauge_i.nominal_full_capacity * factor_q * cold);
        corr = prod[39:FGR_CORR_SHIFT];
        if (!nrst_i)
        begin
            comp_q <= FGR_RST_WORD;
        end
        else
        begin
            comp_q <= (corr >= {3'h0, gauge_i.nominal_full_capacity}) ?
                16'h0000 : gauge_i.nominal_full_capacity - corr[15:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            factor_q <= FGR_RST_CORR;
        end
        else if (wr_factor)
        begin
            factor_q <= req_i.wdata;
        end
    end

    assign compensated_full_capacity_o = comp_q;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Whole word captured in one edge; answer one cycle after request
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            rdata_o <= FGR_RST_WORD;
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end
        else
        begin
            ack_o <= req_i.rd || req_i.wr;
            err_o <= (req_i.rd || req_i.wr) && !fgr_mapped(req_i.addr);
            if (rd)
            begin
                unique case (req_i.addr)
                    FGR_OFS_EMPTY_TIME: rdata_o <= empty_q;
                    FGR_OFS_SLOW_RES: rdata_o <= slow_q;
                    FGR_OFS_CYC: rdata_o <= cyc_q;
                    FGR_OFS_AVAIL: rdata_o <= avail_q;
                    FGR_OFS_FULL_TIME: rdata_o <= full_q;
                    FGR_OFS_FCREP: rdata_o <= fcrep_q;
                    FGR_OFS_CORR: rdata_o <= factor_q;
                    FGR_OFS_DQ: rdata_o <= dq_q;
                    FGR_OFS_DP: rdata_o <= dp_q;
                    FGR_OFS_VFREM: rdata_o <= vfrem_q;
                    default: rdata_o <= 16'h0000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ==== verification/fgr_regs_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module fgr_regs_chk
    import fgr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register port
    input wire fgr_req_t req_i,
    input wire logic [15:0] rdata_o,
    input wire logic ack_o,
    input wire logic err_o,
    // Engine side
    input wire fgr_gauge_t gauge_i,
    input wire logic charge_term_i,
    input wire logic [15:0] compensated_full_capacity_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic req_any;
    logic mapped;
    logic pend_q, have_q, dirty_q, term_d_q;
    logic [15:0] last_q;
    assign req_any = req_i.rd | req_i.wr;
    assign mapped = req_i.addr inside {FGR_OFS_EMPTY_TIME, FGR_OFS_SLOW_RES,
        FGR_OFS_CYC, FGR_OFS_AVAIL, FGR_OFS_FULL_TIME, FGR_OFS_FCREP,
        FGR_OFS_CORR, FGR_OFS_DQ, FGR_OFS_DP, FGR_OFS_VFREM};

    // Last captured-capacity read; a late termination marks it stale
    always_ff @(posedge clk_i)
    begin
        pend_q <= nrst_i & req_i.rd & (req_i.addr == FGR_OFS_FCREP);
        term_d_q <= charge_term_i;
        if (!nrst_i)
        begin
            have_q <= 1'b0;
            dirty_q <= 1'b0;
            last_q <= 16'h0000;
        end
        else
        begin
            if (charge_term_i)
                dirty_q <= 1'b1;
            else if (pend_q && !term_d_q)
                dirty_q <= 1'b0;
            if (pend_q)
            begin
                have_q <= 1'b1;
                last_q <= rdata_o;
            end
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_req;
        req_any;
    endsequence
    sequence s_calm;
        $stable(gauge_i) && (gauge_i.temperature >= FGR_TEMP_REF);
    endsequence

    chk_ack_follows_req: assert property (s_req |=> ack_o)
        else $error("ack missing after request");
    chk_ack_no_req: assert property (!req_any |=> !ack_o)
        else $error("ack without request");
    chk_err_unmapped: assert property (req_any && !mapped
        |=> err_o && ack_o)
        else $error("unmapped access not flagged");
    chk_err_mapped: assert property (s_req and mapped |=> !err_o)
        else $error("mapped access flagged");
    chk_rd_unmapped_zero: assert property (req_i.rd && !mapped
        |=> rdata_o == 16'h0000)
        else $error("unmapped read data not zero");
    chk_rdata_hold_idle: assert property (!req_i.rd |=> $stable(rdata_o))
        else $error("read data moved without read");
    chk_fcrep_hold_value: assert property (pend_q && have_q && !dirty_q
        |-> rdata_o == last_q)
        else $error("captured capacity moved without termination");
    chk_comp_warm_nominal: assert property (s_calm [*3]
        |-> compensated_full_capacity_o
        == gauge_i.nominal_full_capacity)
        else $error("compensated capacity not nominal when warm");
endmodule
bind fgr_regs fgr_regs_chk fgr_regs_chk_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .req_i(req_i), .rdata_o(rdata_o), .ack_o(ack_o), .err_o(err_o),
    .gauge_i(gauge_i), .charge_term_i(charge_term_i),
    .compensated_full_capacity_o(compensated_full_capacity_o));
`default_nettype wire

// ==== verification/fgr_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module fgr_host_model
    import fgr_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Register port
    output var fgr_req_t req_o,
    input wire logic [15:0] rdata_i,
    input wire logic ack_i,
    input wire logic err_i
);
    initial req_o = '0;

    // One whole word per transfer; request lasts one cycle as contracted
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [15:0] wd, output logic [15:0] d, output logic e);
        @(posedge clk_i);
        req_o <= '{rd: !wr, wr: wr, addr: a, wdata: wd};
        @(posedge clk_i);
        // Released lines show inverse data so stale values cannot match
        req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~wd};
        #1;
        d = rdata_i;
        e = (ack_i === 1'b1) ? err_i : 1'bx;
    endtask
endmodule
`default_nettype wire

// ==== verification/fgr_regs_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module fgr_regs_tb_top
    import fgr_pkg::*;
;
    logic clk_i, nrst_i, ack, err, smp, rsub, term, socs, quant;
    fgr_req_t req;
    fgr_gauge_t g;
    logic [15:0] rdata, comp;
    int err_total, checks_done, cyc;
    logic [7:0] ofs [10] = '{FGR_OFS_EMPTY_TIME, FGR_OFS_SLOW_RES, FGR_OFS_CYC,
        FGR_OFS_AVAIL, FGR_OFS_FULL_TIME, FGR_OFS_FCREP, FGR_OFS_CORR,
        FGR_OFS_DQ, FGR_OFS_DP, FGR_OFS_VFREM};

    fgr_regs fgr_regs_i (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req),
        .rdata_o(rdata), .ack_o(ack), .err_o(err), .gauge_i(g),
        .sample_i(smp), .rate_sub_en_i(rsub), .charge_term_i(term),
        .soc_step_i(socs), .charge_quantum_i(quant),
        .compensated_full_capacity_o(comp));
    fgr_host_model fgr_host_model_i (.clk_i(clk_i), .req_o(req),
        .rdata_i(rdata), .ack_i(ack), .err_i(err));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    always #12.5 clk_i = ~clk_i;

    // Whole run needs about 250 cycles; a hang is cut at 5000
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] xd,
        input logic xe);
        logic [15:0] d;
        logic e;
        fgr_host_model_i.xfer(1'b0, a, 16'h0000, d, e);
        chk(d, xd);
        chk({15'h0000, e}, {15'h0000, xe});
    endtask

    task automatic wrw(input logic [7:0] a, input logic [15:0] wd);
        logic [15:0] d;
        logic e;
        fgr_host_model_i.xfer(1'b1, a, wd, d, e);
        chk({15'h0000, e}, 16'h0000);
    endtask

    // Pulses: 0 snapshot, 1 termination, 2 soc step, 3 charge quantum
    task automatic pulse(input int k, input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            case (k)
                0: smp <= 1'b1;
                1: term <= 1'b1;
                2: socs <= 1'b1;
                default: quant <= 1'b1;
            endcase
            @(posedge clk_i);
            {smp, term, socs, quant} <= 4'h0;
        end
    endtask

    // Expected quotient, saturated; a non-negative rate means no drain
    function automatic logic [15:0] empty_x(input logic [15:0] av,
        input logic signed [15:0] r);
        logic [31:0] q;
        if (r >= 0)
            return 16'hffff;
        q = ({av, 16'h0000} / 32'(-r)) >> 5;
        return (q > 32'h0000ffff) ? 16'hffff : q[15:0];
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        foreach (ofs[i])
            rdc(ofs[i], (ofs[i] == FGR_OFS_CORR) ? FGR_RST_CORR
                : FGR_RST_WORD, 1'b0);
        rdc(8'h12, 16'h0000, 1'b1);
        $display("TB: test reset done");
    endtask

    task automatic t_snap;
        @(posedge clk_i);
        g.slow_resistance <= 16'h1234;
        g.available_capacity <= 16'h0400;
        g.voltage_gauge_capacity <= 16'h0abc;
        g.time_to_full <= 16'h8a5f;
        g.averaged_current <= -16'sd2048;
        pulse(0, 1);
        rdc(FGR_OFS_SLOW_RES, 16'h1234, 1'b0);
        rdc(FGR_OFS_AVAIL, 16'h0400, 1'b0);
        rdc(FGR_OFS_VFREM, 16'h0abc, 1'b0);
        rdc(FGR_OFS_FULL_TIME, 16'h8a5f, 1'b0);
        wrw(FGR_OFS_AVAIL, 16'h5555);
        rdc(FGR_OFS_AVAIL, 16'h0400, 1'b0);
        repeat (40) @(posedge clk_i);
        rdc(FGR_OFS_EMPTY_TIME, empty_x(16'h0400, -16'sd2048), 1'b0);
        rsub <= 1'b1;
        g.hypothetical_load_rate <= -16'sd1024;
        pulse(0, 1);
        repeat (40) @(posedge clk_i);
        rdc(FGR_OFS_EMPTY_TIME, empty_x(16'h0400, -16'sd1024), 1'b0);
        g.hypothetical_load_rate <= 16'sh0010;
        pulse(0, 1);
        repeat (40) @(posedge clk_i);
        rdc(FGR_OFS_EMPTY_TIME, empty_x(16'h0400, 16'sh0010), 1'b0);
        rsub <= 1'b0;
        $display("TB: test snapshot done");
    endtask

    task automatic t_odo;
        pulse(2, 4);
        rdc(FGR_OFS_CYC, 16'h0002, 1'b0);
        wrw(FGR_OFS_CYC, 16'h0063);
        pulse(2, 2);
        rdc(FGR_OFS_CYC, 16'h0064, 1'b0);
        $display("TB: test odometer done");
    endtask

    task automatic t_fcrep;
        g.reported_remaining_capacity <= 16'h0321;
        pulse(0, 1);
        pulse(1, 1);
        rdc(FGR_OFS_FCREP, 16'h0321, 1'b0);
        g.reported_remaining_capacity <= 16'h0111;
        g.temperature <= 8'sd10;
        pulse(0, 1);
        rdc(FGR_OFS_FCREP, 16'h0321, 1'b0);
        pulse(1, 1);
        rdc(FGR_OFS_FCREP, 16'h0111, 1'b0);
        g.temperature <= 8'sd25;
        $display("TB: test capture done");
    endtask

    task automatic t_learn;
        g.remaining_capacity <= 16'h0010;
        pulse(0, 1);
        pulse(3, 3);
        rdc(FGR_OFS_DQ, 16'h0003, 1'b0);
        pulse(3, 3);
        rdc(FGR_OFS_DQ, 16'h0004, 1'b0);
        g.voltage_gauge_soc <= 16'h0010;
        pulse(0, 1);
        g.voltage_gauge_soc <= 16'h0008;
        pulse(0, 1);
        rdc(FGR_OFS_DP, 16'h0006, 1'b0);
        $display("TB: test learning done");
    endtask

    task automatic t_comp;
        wrw(FGR_OFS_CORR, 16'h8000);
        rdc(FGR_OFS_CORR, 16'h8000, 1'b0);
        g.temperature <= 8'sd24;
        repeat (3) @(posedge clk_i);
        #1 chk(comp, 16'h1000 - 16'h0040);
        g.temperature <= 8'sd25;
        repeat (3) @(posedge clk_i);
        #1 chk(comp, 16'h1000);
        $display("TB: test compensation done");
    endtask

    task automatic wrap_up;
        $display("TB: checks=%0d errors=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        nrst_i = 1'b0;
        {smp, rsub, term, socs, quant} = 5'h00;
        g = '0;
        g.nominal_full_capacity = 16'h1000;
        g.temperature = 8'sd25;
        err_total = 0;
        checks_done = 0;
        cyc = 0;
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_snap();
        t_odo();
        t_fcrep();
        t_learn();
        t_comp();
        wrap_up();
    end
endmodule
`default_nettype wire
